// *** verilog/ref_pulse_defs.svh ***
// constants for the reference pulse input decoder
// assumes a 20 MHz system clock and a word-wide register port
`ifndef REF_PULSE_DEFS_SVH
`define REF_PULSE_DEFS_SVH

// system clock rate
`define CLK_MHZ          20
`define CLK_PERIOD_NS    50

// register offsets (byte addresses, one word each)
`define REG_CONFIG       4'h0
`define REG_FILTER       4'h4
`define REG_POSITION     4'h8
`define REG_STATUS       4'hc

// config register fields
`define CFG_MODE_LSB     0
`define CFG_FORM_LSB     8
`define CFG_INV_LSB      12

// reset values
`define RST_MODE_DIGIT   4'h0
`define RST_FORM_DIGIT   4'h0
`define RST_INV_DIGIT    4'h0
`define RST_FILTER       16'h0000

// control mode tens digit codes
`define MODE_SPEED       4'h0
`define MODE_POSITION    4'h1

// reference form codes
`define FORM_SIGN_PULSE  4'h0
`define FORM_SPLIT       4'h1
`define FORM_QUAD_X1     4'h2
`define FORM_QUAD_X2     4'h3
`define FORM_QUAD_X4     4'h4

// inversion codes: bit 0 inverts direction line, bit 1 pulse line
`define INV_SIGN_BIT     0
`define INV_PULS_BIT     1

// input filter setting thresholds
`define FILTER_SET_MID   16'd1000
`define FILTER_SET_SLOW  16'd2000

// highest accepted pulse rate per setting, in kHz
`define RATE_FAST_KHZ    4000
`define RATE_MID_KHZ     650
`define RATE_SLOW_KHZ    150

`endif

// *** verilog/ref_pulse_pkg.sv ***
// types for the reference pulse input decoder
// assumes ref_pulse_defs.svh for all numeric constants
package ref_pulse_pkg;

	// software configuration, as held in the registers
	typedef struct packed {
		logic [3:0]  mode_digit;   // control mode tens digit
		logic [3:0]  form_digit;   // pulse form hundreds digit
		logic [3:0]  inv_digit;    // inversion thousands digit
		logic [15:0] filter_set;   // input filter setting
	} cfg_t;

	// one decoded position step
	typedef struct packed {
		logic valid;               // a step happened this cycle
		logic reverse;             // step is in reverse direction
	} step_t;

endpackage

// *** verilog/pulse_glitch_filter.sv ***
// level filter for one reference input line
// assumes an already synchronised input on the same clock
`timescale 1ns/1ns
`default_nettype none

module pulse_glitch_filter (
	input  wire logic       sys_clk,     // system clock
	input  wire logic       rst,         // async reset, active high
	input  wire logic       raw_level,   // synchronised line level
	input  wire logic [7:0] stable_cnt,  // cycles a new level must hold
	output logic            clean_level  // filtered line level
);

	logic [7:0] run_cnt;  // cycles the differing level has held

	// count how long the line has differed; flip once it held long enough
	// short glitches restart the count, so only wide pulses pass
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			run_cnt     <= 8'h00;
			clean_level <= 1'b0;
		end else if (raw_level == clean_level) begin
			run_cnt <= 8'h00;
		end else if (run_cnt + 8'h01 >= stable_cnt) begin
			run_cnt     <= 8'h00;
			clean_level <= raw_level;
		end else begin
			run_cnt <= run_cnt + 8'h01;
		end
	end

endmodule

`default_nettype wire

// *** verilog/reference_pulse_input_decoder.sv ***
// reference pulse input decoder: pulse train to signed position steps
// assumes the differential receivers deliver pulse and sign as logic levels
// asynchronous to sys_clk; positioning-done and speed-match come from
// the servo loop on sys_clk
//
// Contract
// R1: accept pulses only in position control mode
// R2: filter setting caps accepted pulse rate
// R3: hundreds digit selects reference pulse form
// R4: sign plus pulse: high sign is forward
// R5: multiplier applies only to quadrature form
// R6: thousands digit inverts sign and/or pulse
// R7: shared pin: done in position, match speed
// R8: quadrature direction from leading line, x1/x2/x4
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`include "ref_pulse_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module reference_pulse_input_decoder #(
	parameter int POS_WIDTH = 32  // width of the position accumulator
) (
	input  wire logic                 sys_clk,          // system clock, 20 MHz
	input  wire logic                 rst,              // async reset, active high
	input  wire logic                 pulse_line_in,    // pulse line from receiver
	input  wire logic                 sign_line_in,     // sign line from receiver
	input  wire logic                 positioning_done, // servo loop: in position
	input  wire logic                 speed_match,      // servo loop: speed coincides
	input  wire logic [3:0]           reg_addr,         // register byte address
	input  wire logic [31:0]          reg_wdata,        // register write data
	input  wire logic                 reg_wr,           // write strobe
	input  wire logic                 reg_rd,           // read strobe
	output logic      [31:0]          reg_rdata,        // read data, cycle after
	output ref_pulse_pkg::step_t      step,             // decoded step pulse
	output logic signed [POS_WIDTH-1:0] position,       // accumulated steps
	output logic                      shared_status_n   // shared pin, low = on
);

	// filter lengths: half the shortest period at each rate, rounded down
	localparam int FAST_CYC = (`CLK_MHZ * 1000) / (2 * `RATE_FAST_KHZ);
	localparam int MID_CYC  = (`CLK_MHZ * 1000) / (2 * `RATE_MID_KHZ);
	localparam int SLOW_CYC = (`CLK_MHZ * 1000) / (2 * `RATE_SLOW_KHZ);

	ref_pulse_pkg::cfg_t cfg;        // software configuration
	logic [1:0]  pulse_sync;         // pulse line synchroniser
	logic [1:0]  sign_sync;          // sign line synchroniser
	logic [7:0]  filt_len;           // selected filter length
	logic        pulse_clean;        // filtered pulse line
	logic        sign_clean;         // filtered sign line
	logic        pulse_lvl;          // pulse after optional inversion
	logic        sign_lvl;           // sign after optional inversion
	logic        pulse_prev;         // pulse level last cycle
	logic        sign_prev;          // sign level last cycle
	logic        pos_mode;           // position control selected
	logic        next_valid;         // step found this cycle
	logic        next_reverse;       // its direction
	logic        positioning_done_out; // done, gated to position mode
	logic        speed_match_out;      // match, gated to speed mode

	// true when the line changed between two cycles
	function automatic logic edge_of(input logic now, input logic was);
		edge_of = now ^ was;
	endfunction

	// register writes, only the config words are writable
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg.mode_digit <= `RST_MODE_DIGIT;
			cfg.form_digit <= `RST_FORM_DIGIT;
			cfg.inv_digit  <= `RST_INV_DIGIT;
			cfg.filter_set <= `RST_FILTER;
		end else if (reg_wr) begin
			case (reg_addr)
				`REG_CONFIG: begin
					cfg.mode_digit <= reg_wdata[`CFG_MODE_LSB +: 4];
					cfg.form_digit <= reg_wdata[`CFG_FORM_LSB +: 4];
					cfg.inv_digit  <= reg_wdata[`CFG_INV_LSB +: 4];
				end
				`REG_FILTER: begin
					cfg.filter_set <= reg_wdata[15:0];
				end
				default: begin
					// read-only or unmapped: ignored
				end
			endcase
		end
	end

	// register reads, data valid the cycle after the strobe only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_CONFIG: begin
					reg_rdata <= {16'h0000, cfg.inv_digit, cfg.form_digit,
						4'h0, cfg.mode_digit};
				end
				`REG_FILTER: begin
					reg_rdata <= {16'h0000, cfg.filter_set};
				end
				`REG_POSITION: begin
					reg_rdata <= 32'(position);
				end
				`REG_STATUS: begin
					reg_rdata <= {28'h000_0000, ~shared_status_n, sign_lvl,
						pulse_lvl, pos_mode};
				end
				default: begin
					// unmapped reads as zero
					reg_rdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// R1: mode digit gate
	assign pos_mode = (cfg.mode_digit == `MODE_POSITION);

	// two-stage synchronisers; only stage 1 reads stage 0
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pulse_sync <= 2'b00;
			sign_sync  <= 2'b00;
		end else begin
			pulse_sync <= {pulse_sync[0], pulse_line_in};
			sign_sync  <= {sign_sync[0], sign_line_in};
		end
	end

	// R2: rate limit select
	// the fastest rate leaves only a couple of samples per level at 20 MHz,
	// so the drive must not be fed faster than the selected figure
	always_comb begin
		if (cfg.filter_set >= `FILTER_SET_SLOW) begin
			filt_len = 8'(SLOW_CYC);
		end else if (cfg.filter_set >= `FILTER_SET_MID) begin
			filt_len = 8'(MID_CYC);
		end else begin
			filt_len = 8'(FAST_CYC);
		end
	end

	// R2: filter each line
	pulse_glitch_filter u_pulse_filt (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.raw_level   (pulse_sync[1]),
		.stable_cnt  (filt_len),
		.clean_level (pulse_clean)
	);

	// sign line gets the same filter so both keep their phase relation
	pulse_glitch_filter u_sign_filt (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.raw_level   (sign_sync[1]),
		.stable_cnt  (filt_len),
		.clean_level (sign_clean)
	);

	// R6: optional line inversion
	assign pulse_lvl = pulse_clean ^ cfg.inv_digit[`INV_PULS_BIT];
	assign sign_lvl  = sign_clean ^ cfg.inv_digit[`INV_SIGN_BIT];

	// previous levels for edge detection
	// an inversion change looks like an edge; change config while idle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pulse_prev <= 1'b0;
			sign_prev  <= 1'b0;
		end else begin
			pulse_prev <= pulse_lvl;
			sign_prev  <= sign_lvl;
		end
	end

	// R3: decode by selected form
	always_comb begin
		next_valid   = 1'b0;
		next_reverse = 1'b0;
		case (cfg.form_digit)
			`FORM_SIGN_PULSE: begin
				// R4: rising pulse, sign sets direction
				next_valid   = pulse_lvl & ~pulse_prev;
				next_reverse = ~sign_lvl;
			end
			`FORM_SPLIT: begin
				// R5: one step per pulse, pulse line forward
				if (pulse_lvl & ~pulse_prev) begin
					next_valid   = 1'b1;
					next_reverse = 1'b0;
				end else if (sign_lvl & ~sign_prev) begin
					next_valid   = 1'b1;
					next_reverse = 1'b1;
				end
			end
			`FORM_QUAD_X1: begin
				// R8: x1, pulse edges while sign low
				next_valid   = edge_of(pulse_lvl, pulse_prev) & ~sign_lvl;
				next_reverse = ~pulse_lvl;
			end
			`FORM_QUAD_X2: begin
				// R8: x2, every pulse line edge
				next_valid   = edge_of(pulse_lvl, pulse_prev);
				next_reverse = (pulse_lvl == sign_lvl);
			end
			`FORM_QUAD_X4: begin
				// R8: x4, edges of both lines
				// both lines moving at once is an illegal jump and is dropped
				if (edge_of(pulse_lvl, pulse_prev) && !edge_of(sign_lvl, sign_prev)) begin
					next_valid   = 1'b1;
					next_reverse = (pulse_lvl == sign_lvl);
				end else if (edge_of(sign_lvl, sign_prev) &&
					!edge_of(pulse_lvl, pulse_prev)) begin
					next_valid   = 1'b1;
					next_reverse = (sign_lvl != pulse_lvl);
				end
			end
			default: begin
				// unknown form codes give no steps
				next_valid   = 1'b0;
				next_reverse = 1'b0;
			end
		endcase
	end

	// R1: steps only in position mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			step <= '0;
		end else begin
			step.valid   <= next_valid & pos_mode;
			step.reverse <= next_reverse & next_valid & pos_mode;
		end
	end

	// position accumulator, wraps at its width
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			position <= '0;
		end else if (step.valid) begin
			if (step.reverse) begin
				position <= position - POS_WIDTH'(1);
			end else begin
				position <= position + POS_WIDTH'(1);
			end
		end
	end

	// R7: shared pin source
	assign positioning_done_out = pos_mode & positioning_done;
	assign speed_match_out      = (cfg.mode_digit == `MODE_SPEED) & speed_match;

	// R7: pin is active low, off in other modes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shared_status_n <= 1'b1;
		end else begin
			shared_status_n <= ~(positioning_done_out | speed_match_out);
		end
	end

endmodule

`default_nettype wire

// *** tb/ref_pulse_properties.sv ***
// port assertions for the reference pulse decoder
// assumes one clock domain, bound to the decoder top
`timescale 1ns/1ns
`default_nettype none
module ref_pulse_checker #(parameter int POS_WIDTH = 32) (
	input wire logic	sys_clk,
	input wire logic	rst,
	input wire logic	positioning_done,
	input wire logic	speed_match,
	input wire logic [3:0]	reg_addr,
	input wire logic [31:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [31:0]	reg_rdata,
	input wire ref_pulse_pkg::step_t	step,
	input wire logic signed [POS_WIDTH-1:0]	position,
	input wire logic	shared_status_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [3:0]	mode;	// shadow of the mode digit
	// shadow follows config writes on the same edge as the design
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) mode <= 4'h0;
		else if (reg_wr && reg_addr == 4'h0) mode <= reg_wdata[3:0];
	end
	// step is registered, so it follows the mode of the cycle before
	property p_speed_idle; $past(mode) != 4'h1 |-> !step.valid; endproperty
	a_speed_idle: assert property (p_speed_idle) else $error("step outside position mode");
	property p_shared; 1 |=> shared_status_n == !($past(mode) == 4'h1 ?
		$past(positioning_done) : $past(mode) == 4'h0 && $past(speed_match)); endproperty
	a_shared: assert property (p_shared) else $error("shared pin wrong");
	property p_fwd; step.valid && !step.reverse |=> position == $past(position) + 1; endproperty
	a_fwd: assert property (p_fwd) else $error("forward step not counted");
	property p_rev; step.valid && step.reverse |=> position == $past(position) - 1; endproperty
	a_rev: assert property (p_rev) else $error("reverse step not counted");
	property p_hold; !step.valid |=> $stable(position); endproperty
	a_hold: assert property (p_hold) else $error("position moved without step");
	property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rd_pos; reg_rd && reg_addr == 4'h8 |=> reg_rdata == 32'($past(position));
	endproperty
	a_rd_pos: assert property (p_rd_pos) else $error("position read wrong");
	property p_rd_stat; reg_rd && reg_addr == 4'hc |=> reg_rdata[0] == ($past(mode) == 4'h1);
	endproperty
	a_rd_stat: assert property (p_rd_stat) else $error("mode status wrong");
	property p_unmap; reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind reference_pulse_input_decoder ref_pulse_checker #(.POS_WIDTH(POS_WIDTH)) chk_u (
	.sys_clk(sys_clk), .rst(rst), .positioning_done(positioning_done),
	.speed_match(speed_match), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step(step),
	.position(position), .shared_status_n(shared_status_n));
`default_nettype wire

// *** tb/pulse_host_model.sv ***
// host controller model driving the pulse and sign pins
// assumes the bench calls its tasks; pins change after a rising edge
`timescale 1ns/1ns
`default_nettype none
module pulse_host_model (
	input wire logic	sys_clk,	// system clock
	output logic	pulse_line,	// pulse pin
	output logic	sign_line	// sign pin
);
	logic	p = 1'b0;	// logical pulse level
	logic	s = 1'b0;	// logical sign level
	logic [1:0]	inv = 2'h0;	// bit1 pulse, bit0 sign
	assign pulse_line = p ^ inv[1];
	assign sign_line = s ^ inv[0];
	task automatic lv(input logic np, ns, input int h);
		@(posedge sys_clk);
		p <= np;
		s <= ns;
		repeat (h - 1) @(posedge sys_clk);
	endtask
	// rest levels with a new inversion, pins flip together
	task automatic idle(input logic [1:0] i);
		@(posedge sys_clk);
		p <= 1'b0;
		s <= 1'b0;
		inv <= i;
	endtask
	task automatic send(input logic [3:0] f, input logic r, input int n, h);
		for (int k = 0; k < n; k++) begin
			if (f == 4'h0) begin
				lv(1'b0, !r, h);
				lv(1'b1, !r, h);
				lv(1'b0, !r, h);
			end else if (f == 4'h1) begin
				lv(!r, r, h);
				lv(1'b0, 1'b0, h);
			end else begin
				lv(!r, r, h);
				lv(1'b1, 1'b1, h);
				lv(r, !r, h);
				lv(1'b0, 1'b0, h);
			end
		end
		lv(1'b0, 1'b0, h);
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the reference pulse decoder
// assumes decoder, checker and host model are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic	sys_clk = 1'b0;
	logic	rst = 1'b1;
	logic	done_in = 1'b0;	// servo in position
	logic	match_in = 1'b0;	// servo speed match
	logic [3:0]	reg_addr = 4'h0;
	logic [31:0]	reg_wdata = 32'h0;
	logic	reg_wr = 1'b0;
	logic	reg_rd = 1'b0;
	logic	pulse_w;
	logic	sign_w;
	logic [31:0]	reg_rdata;
	ref_pulse_pkg::step_t	step;
	logic signed [31:0]	position;
	logic	shared_n;	// shared pin, low active
	logic signed [31:0]	exp_pos = 32'h0;
	logic [31:0]	d;	// last read word
	int	num_errors = 0;
	int	num_checks = 0;
	int	cyc = 0;
	always #25 sys_clk = ~sys_clk;
	reference_pulse_input_decoder dut_u (.sys_clk(sys_clk), .rst(rst), .pulse_line_in(pulse_w),
		.sign_line_in(sign_w), .positioning_done(done_in), .speed_match(match_in),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .step(step), .position(position), .shared_status_n(shared_n));
	pulse_host_model host_u (.sys_clk(sys_clk), .pulse_line(pulse_w), .sign_line(sign_w));
	task automatic report_and_stop;
		if (num_errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// a hang ends the run as a failure
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop;
		end
	end
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// read word stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic cfg(input logic [3:0] m, f, i);
		wr(4'h0, {16'h0, i, f, 4'h0, m});
	endtask
	// k is the count per pulse cycle, 0 where refused
	task automatic go(input logic [3:0] f, input logic r, input int n, h, k);
		exp_pos = r ? exp_pos - n * k : exp_pos + n * k;
		host_u.send(f, r, n, h);
		settle(80);
		check(position, exp_pos);
	endtask
	task automatic t_regs;
		rd(4'h0);
		check(d, 32'h0);
		wr(4'h8, 32'h55);
		rd(4'h8);
		check(d, 32'h0);
		rd(4'h2);
		check(d, 32'h0);
		wr(4'h4, 32'd1000);
		rd(4'h4);
		check(d, 32'd1000);
		wr(4'h4, 32'h0);
	endtask
	task automatic t_shared;
		// mode 2 is neither speed nor position: pin off, no steps
		for (int m = 0; m < 3; m++) begin
			cfg(4'(m), 4'h0, 4'h0);
			for (int v = 0; v < 4; v++) begin
				@(posedge sys_clk);
				done_in <= v[0];
				match_in <= v[1];
				settle(3);
				check(32'(shared_n), 32'(m == 1 ? !v[0] : m == 0 ? !v[1] : 1'b1));
				rd(4'hc);
				check(32'(d[0]), 32'(m == 1));
				check(32'(d[3:1]), 32'({m == 1 ? v[0] : m == 0 ? v[1] : 1'b0, 2'b00}));
			end
		end
		go(4'h0, 1'b0, 3, 4, 0);
	endtask
	// every form under every inversion, both directions
	task automatic t_forms;
		for (int f = 0; f < 5; f++) begin
			for (int i = 0; i < 4; i++) begin
				cfg(4'h0, 4'(f), 4'(i));
				host_u.idle(2'(i));
				settle(10);
				cfg(4'h1, 4'(f), 4'(i));
				go(4'(f), 1'b0, 2, 4, f == 3 ? 2 : f == 4 ? 4 : 1);
				go(4'(f), 1'b1, 1, 4, f == 3 ? 2 : f == 4 ? 4 : 1);
			end
		end
	endtask
	// short pulses under the slower filters are dropped
	task automatic t_filter;
		cfg(4'h1, 4'h5, 4'h3);
		go(4'h5, 1'b0, 1, 4, 0);
		cfg(4'h1, 4'h0, 4'h3);
		wr(4'h4, 32'd1000);
		go(4'h0, 1'b0, 2, 8, 0);
		go(4'h0, 1'b0, 2, 20, 1);
		cfg(4'h1, 4'h1, 4'h3);
		wr(4'h4, 32'd2000);
		go(4'h1, 1'b1, 1, 40, 0);
		go(4'h1, 1'b1, 1, 70, 1);
		rd(4'h8);
		check(d, exp_pos);
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_shared;
		t_forms;
		t_filter;
		report_and_stop;
	end
endmodule
`default_nettype wire
